/* hw/nand_host_pkg.sv */
package nand_host_pkg;

	// ---------------------------------------------------------------
	// Opcodes, ID and status constants
	// ---------------------------------------------------------------
	localparam logic [7:0] OP_READ       = 8'h00;
	localparam logic [7:0] OP_READ_GO    = 8'h30;
	localparam logic [7:0] OP_RAND_RD    = 8'h05;
	localparam logic [7:0] OP_RAND_GO    = 8'he0;
	localparam logic [7:0] OP_CACHE_NEXT = 8'h31;
	localparam logic [7:0] OP_CACHE_LAST = 8'h3f;
	localparam logic [7:0] OP_READ_ID    = 8'h90;
	localparam logic [7:0] OP_STATUS     = 8'h70;
	localparam logic [7:0] OP_RESET      = 8'hff;
	localparam logic [7:0] ID_ADDR       = 8'h00;
	localparam logic [7:0] STATUS_READY  = 8'he0;
	localparam int         SR_RDY_BIT    = 6;
	localparam int         SR_ARY_BIT    = 5;
	localparam logic [2:0] ID_LEN        = 3'h5;

	// ---------------------------------------------------------------
	// Strobe timing
	// ---------------------------------------------------------------
	localparam int CLK_NS     = 8;
	localparam int PHASE_NS   = 24;
	localparam int PHASE_CYC  = (PHASE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] PHASE_LAST = 4'(PHASE_CYC - 1);

	// ---------------------------------------------------------------
	// Request kinds and carriers
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		REQ_PAGE, REQ_RAND, REQ_CACHE, REQ_LAST, REQ_ID, REQ_POLL_PAGE
	} req_kind_type;

	typedef struct packed {
		req_kind_type kind;
		logic [15:0]  col;
		logic [15:0]  row;
		logic [11:0]  count;
	} req_type;

	typedef struct packed {
		logic ce_n;
		logic cle;
		logic ale;
		logic we_n;
		logic re_n;
	} pins_type;

endpackage : nand_host_pkg

/* hw/nand_read_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Page read is 00h, address, 30h.
// - Rewrite 00h after status polling.
// - Send 00h only when ready.
// - Random column: 05h, two columns, E0h.
// - 90h then 00h reads five ID bytes.
// - Random column stays in page.
// - Command latched: CLE high, WE rise.
// - Four address cycles, random uses two.
// - Address latched: ALE high, WE rise.
module nand_read_host
	import nand_host_pkg::*;
(
	// Clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        SRST,
	// Request port
	input  wire logic        REQ_VALID,
	input  wire req_type     REQ,
	output var  logic        REQ_READY,
	output var  logic        DATA_VALID,
	output var  logic [15:0] DATA,
	output var  logic        DONE,
	// Flash pins
	output var  pins_type    PINS,
	output var  logic [15:0] IO_OUT,
	output var  logic        IO_OE,
	input  wire logic [15:0] IO_IN,
	input  wire logic        READY_BUSY_N
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef enum {
		S_IDLE, S_CMD1, S_ADDR, S_CMD2, S_WAIT, S_STAT_CMD, S_STAT_RD,
		S_RERD, S_DATA, S_END
	} state_type;

	state_type    state_r;
	req_type      req_r;
	logic [3:0]   phase_r;
	logic [1:0]   step_r;
	logic [2:0]   acnt_r;
	logic [11:0]  left_r;
	logic [1:0]   rb_sync_r;
	logic [15:0]  io_sync0_r;
	logic [15:0]  io_sync1_r;
	logic         seen_busy_r;
	logic [2:0]   nadr;
	logic [7:0]   cmd1;
	logic [7:0]   cmd2;
	logic         has_cmd2;
	logic         phase_end;

	assign phase_end = (phase_r == PHASE_LAST);

	// Opcodes and address cycle count per request kind.
	always_comb begin
		cmd1     = OP_READ;
		cmd2     = OP_READ_GO;
		has_cmd2 = 1'b1;
		nadr     = 3'h4;
		case (req_r.kind)
			REQ_PAGE, REQ_POLL_PAGE: begin
				cmd1 = OP_READ;
			end
			REQ_RAND: begin
				cmd1 = OP_RAND_RD;
				cmd2 = OP_RAND_GO;
				nadr = 3'h2;
			end
			REQ_CACHE: begin
				cmd1     = OP_CACHE_NEXT;
				has_cmd2 = 1'b0;
				nadr     = 3'h0;
			end
			REQ_LAST: begin
				cmd1     = OP_CACHE_LAST;
				has_cmd2 = 1'b0;
				nadr     = 3'h0;
			end
			REQ_ID: begin
				cmd1     = OP_READ_ID;
				has_cmd2 = 1'b0;
				nadr     = 3'h1;
			end
			default: begin
				cmd1 = OP_READ;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// Synchronisers
	// ---------------------------------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			rb_sync_r  <= 2'b11;
			io_sync0_r <= 16'h0000;
			io_sync1_r <= 16'h0000;
		end else begin
			rb_sync_r  <= {rb_sync_r[0], READY_BUSY_N};
			io_sync0_r <= IO_IN;
			io_sync1_r <= io_sync0_r;
		end
	end

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	// Each write bus cycle is a setup, strobe-low, strobe-high phase triple (reads a low-high pair); the
	// flash latches on the write strobe rising edge at the phase change.
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			state_r     <= S_IDLE;
			req_r       <= '0;
			phase_r     <= 4'h0;
			step_r      <= 2'h0;
			acnt_r      <= 3'h0;
			left_r      <= 12'h000;
			seen_busy_r <= 1'b0;
			PINS        <= '{ce_n:1'b1, cle:1'b0, ale:1'b0, we_n:1'b1,
				re_n:1'b1};
			IO_OUT      <= 16'h0000;
			IO_OE       <= 1'b0;
			REQ_READY   <= 1'b0;
			DATA_VALID  <= 1'b0;
			DATA        <= 16'h0000;
			DONE        <= 1'b0;
		end else begin
			DATA_VALID <= 1'b0;
			DONE       <= 1'b0;
			phase_r    <= phase_end ? 4'h0 : phase_r + 4'h1;
			case (state_r)
				S_IDLE: begin
					PINS.ce_n <= 1'b1;
					REQ_READY <= rb_sync_r[1];
					phase_r   <= 4'h0;
					step_r    <= 2'h0;
					// Requests wait for ready so the device never drops them.
					if (REQ_VALID && REQ_READY && rb_sync_r[1]) begin
						req_r     <= REQ;
						REQ_READY <= 1'b0;
						PINS.ce_n <= 1'b0;
						state_r   <= S_CMD1;
						acnt_r    <= 3'h0;
					end
				end
				S_CMD1, S_CMD2, S_STAT_CMD, S_RERD: begin
					PINS.cle <= 1'b1;
					PINS.ale <= 1'b0;
					IO_OE    <= 1'b1;
					IO_OUT   <= {8'h00,
						(state_r == S_CMD1) ? cmd1 :
						(state_r == S_CMD2) ? cmd2 :
						(state_r == S_STAT_CMD) ? OP_STATUS : OP_READ};
					// A hold phase keeps CLE and data steady past the latch edge.
					if (phase_end) begin
						step_r    <= step_r + 2'h1;
						PINS.we_n <= (step_r != 2'h0);
						if (step_r == 2'h2) begin
							PINS.cle <= 1'b0;
							IO_OE    <= 1'b0;
							step_r   <= 2'h0;
							seen_busy_r <= 1'b0;
							case (state_r)
								S_CMD1: state_r <= (nadr != 3'h0) ? S_ADDR :
									has_cmd2 ? S_CMD2 : S_WAIT;
								S_CMD2: state_r <= S_WAIT;
								S_STAT_CMD: state_r <= S_STAT_RD;
								default: state_r <= S_DATA;
							endcase
						end
					end
				end
				S_ADDR: begin
					PINS.ale <= 1'b1;
					IO_OE    <= 1'b1;
					case (acnt_r)
						3'h0: IO_OUT <= {8'h00, (req_r.kind == REQ_ID) ?
							ID_ADDR : req_r.col[7:0]};
						3'h1: IO_OUT <= {8'h00, req_r.col[15:8]};
						3'h2: IO_OUT <= {8'h00, req_r.row[7:0]};
						default: IO_OUT <= {8'h00, req_r.row[15:8]};
					endcase
					// A hold phase keeps ALE and data steady past the latch edge.
					if (phase_end) begin
						step_r    <= step_r + 2'h1;
						PINS.we_n <= (step_r != 2'h0);
						if (step_r == 2'h2) begin
							step_r <= 2'h0;
							acnt_r <= acnt_r + 3'h1;
							if (acnt_r + 3'h1 == nadr) begin
								PINS.ale <= 1'b0;
								IO_OE    <= 1'b0;
								state_r  <= has_cmd2 ? S_CMD2 : S_WAIT;
							end
						end
					end
				end
				S_WAIT: begin
					// Ready may need time to fall; unless busy was seen, wait four phases before trusting high.
					if (!rb_sync_r[1]) begin
						seen_busy_r <= 1'b1;
					end
					left_r <= (req_r.kind == REQ_ID) ? 12'(ID_LEN) : req_r.count;
					// Early exits restart the phase so the first strobe is full width.
					if (req_r.kind == REQ_ID || req_r.kind == REQ_RAND) begin
						state_r <= S_DATA;
						phase_r <= 4'h0;
						step_r  <= 2'h0;
					end else if (req_r.kind == REQ_POLL_PAGE) begin
						state_r <= S_STAT_CMD;
						phase_r <= 4'h0;
						step_r  <= 2'h0;
					end else if (phase_end && rb_sync_r[1] &&
							(seen_busy_r || step_r == 2'h3)) begin
						state_r <= S_DATA;
						step_r  <= 2'h0;
					end else if (phase_end && step_r != 2'h3) begin
						step_r <= step_r + 2'h1;
					end
				end
				S_STAT_RD: begin
					PINS.re_n <= step_r[0];
					if (phase_end) begin
						step_r <= step_r + 2'h1;
						// The synchroniser delay means this byte was caught while low.
						if (step_r[0]) begin
							step_r    <= 2'h0;
							if (io_sync1_r[SR_RDY_BIT] && io_sync1_r[SR_ARY_BIT] &&
									io_sync1_r[7:0] == STATUS_READY) begin
								state_r <= S_RERD;
							end
						end
					end
				end
				S_DATA: begin
					if (left_r == 12'h000) begin
						state_r <= S_END;
					end else begin
						PINS.re_n <= step_r[0];
						if (phase_end) begin
							step_r <= step_r + 2'h1;
							if (step_r[0]) begin
								// Sampled two cycles late through the synchroniser.
								DATA_VALID <= 1'b1;
								DATA       <= io_sync1_r;
								left_r     <= left_r - 12'h001;
								step_r     <= 2'h0;
							end
						end
					end
				end
				default: begin
					PINS.re_n <= 1'b1;
					PINS.ce_n <= 1'b1;
					DONE      <= 1'b1;
					state_r   <= S_IDLE;
				end
			endcase
		end
	end

endmodule : nand_read_host
`default_nettype wire

/* dv/nand_read_host_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ------
// Pin checks
// ------
module nand_read_host_props
	import nand_host_pkg::*;
(
	// Watched ports
	input wire logic        SYS_CLK,
	input wire logic        SRST,
	input wire logic        REQ_READY,
	input wire logic        DONE,
	input wire pins_type    PINS,
	input wire logic [15:0] IO_OUT,
	input wire logic        IO_OE,
	input wire logic        READY_BUSY_N
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SRST);
	sequence we_pulse;
		!PINS.we_n [*2] ##1 PINS.we_n;
	endsequence
	sequence re_pulse;
		!PINS.re_n [*2] ##1 PINS.re_n;
	endsequence
	reset_idle_a: assert property ($fell(SRST) |->
		PINS.ce_n && PINS.we_n && PINS.re_n && !IO_OE) else $error("idle");
	cmd_latch_a: assert property ($rose(PINS.we_n) && PINS.cle |->
		!PINS.ale && !PINS.ce_n && $past(IO_OE)) else $error("cmd latch");
	addr_latch_a: assert property ($rose(PINS.we_n) && PINS.ale |->
		!PINS.cle && !PINS.ce_n && $past(IO_OE)) else $error("addr latch");
	write_width_a: assert property ($fell(PINS.we_n) |=> we_pulse)
		else $error("we width");
	read_strobe_a: assert property ($fell(PINS.re_n) |->
		(!PINS.cle && !PINS.ale && !IO_OE) ##1 re_pulse) else $error("re");
	busy_cmd_a: assert property (!READY_BUSY_N [*3] ##0
		($rose(PINS.we_n) && PINS.cle) |-> $past(IO_OUT) == {8'h00, OP_STATUS})
		else $error("cmd while busy");
	ready_gate_a: assert property (REQ_READY |-> $past(READY_BUSY_N, 3))
		else $error("ready while busy");
	done_deselect_a: assert property (DONE |-> ##[0:8] PINS.ce_n)
		else $error("no deselect");
endmodule : nand_read_host_props
bind nand_read_host nand_read_host_props nand_read_host_props_i (.SYS_CLK,
	.SRST, .REQ_READY, .DONE, .PINS, .IO_OUT, .IO_OE, .READY_BUSY_N);
`default_nettype wire

/* dv/nand_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------
// Flash device
// ------
module nand_flash_model
	import nand_host_pkg::*;
#(
	parameter int FETCH_CYC = 40,
	parameter int CACHE_CYC = 6
)
(
	// Busy timing
	input  wire logic        clk,
	// Flash pins
	input  wire pins_type    pins,
	input  wire logic [15:0] din,
	output var  logic [15:0] dout,
	output var  logic        rb_low
);
	logic [7:0]  cmd_r = '0;
	logic [15:0] col_r = '0;
	logic [3:0]  cpg_r = '0;
	logic [3:0]  dpg_r = '0;
	logic        id_r = 1'b0;
	logic        st_r = 1'b0;
	int          na_r = 0;
	int          busy_r = 0;
	int          bg_r = 0;
	initial dout = '0;
	assign rb_low = busy_r != 0;
	always @(posedge clk) begin
		if (busy_r > 0) busy_r--;
		if (bg_r > 0) bg_r--;
	end
	always @(posedge pins.we_n) begin
		if (!pins.ce_n && pins.cle && !pins.ale &&
			(busy_r == 0 || din[7:0] == OP_STATUS)) begin
			cmd_r = din[7:0];
			na_r = 0;
			st_r = din[7:0] == OP_STATUS;
			if (din[7:0] == OP_READ_GO) begin
				cpg_r = dpg_r;
				busy_r = FETCH_CYC;
			end
			if (din[7:0] == OP_CACHE_NEXT) begin
				cpg_r = dpg_r;
				dpg_r = dpg_r + 4'h1;
				col_r = '0;
				busy_r = bg_r > CACHE_CYC ? bg_r : CACHE_CYC;
				bg_r = FETCH_CYC;
			end
			if (din[7:0] == OP_CACHE_LAST) begin
				cpg_r = dpg_r;
				col_r = '0;
				busy_r = bg_r > CACHE_CYC ? bg_r : CACHE_CYC;
			end
		end else if (!pins.ce_n && pins.ale && !pins.cle) begin
			if (na_r == 0) col_r[7:0] = din[7:0];
			if (na_r == 1) col_r[15:8] = din[7:0];
			if (na_r == 2 && cmd_r == OP_READ) dpg_r = din[3:0];
			id_r = cmd_r == OP_READ_ID && din[7:0] == ID_ADDR;
			na_r++;
		end
	end
	// A deselected part no longer holds the bus, so the old value is flipped.
	always @(posedge pins.ce_n) dout = ~dout;
	// A released read strobe lets go of the bus, so the old value is flipped.
	always @(posedge pins.re_n) begin
		dout = ~dout;
		if (!st_r) col_r++;
	end
	always @(negedge pins.re_n) if (!pins.ce_n)
		dout = st_r ? {8'h00, rb_low ? 8'h00 : STATUS_READY}
			: id_r ? {8'h00, 8'hc0 + col_r[7:0]} : {cpg_r, col_r[11:0]};
endmodule : nand_flash_model
`default_nettype wire

/* dv/nand_read_command_path_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module nand_read_command_path_tb;
	import nand_host_pkg::*;
	// ------
	// Harness
	// ------
	logic        SYS_CLK = 1'b0;
	logic        SRST = 1'b1;
	logic        REQ_VALID = 1'b0;
	req_type     REQ = '0;
	logic        REQ_READY, DATA_VALID, DONE, IO_OE, rb_low;
	logic [15:0] DATA, IO_OUT, dev_out, io_bus;
	pins_type    PINS;
	int          fails = 0;
	int          checks_done = 0;
	assign io_bus = IO_OE ? IO_OUT : dev_out;
	nand_read_host nand_read_host_i (.SYS_CLK, .SRST, .REQ_VALID, .REQ,
		.REQ_READY, .DATA_VALID, .DATA, .DONE, .PINS, .IO_OUT, .IO_OE,
		.IO_IN(io_bus), .READY_BUSY_N(!rb_low));
	nand_flash_model nand_flash_model_i (.clk(SYS_CLK), .pins(PINS),
		.din(io_bus), .dout(dev_out), .rb_low);
	initial forever #4 SYS_CLK = ~SYS_CLK;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic xfer(input string nm, input req_type rq, logic [15:0] e0);
		int n;
		int t;
		n = 0;
		t = 0;
		@(posedge SYS_CLK);
		REQ <= rq;
		REQ_VALID <= 1'b1;
		do @(posedge SYS_CLK); while (REQ_READY !== 1'b1 && ++t < 5000);
		REQ_VALID <= 1'b0;
		while (DONE !== 1'b1 && t < 20000) begin
			@(posedge SYS_CLK);
			t++;
			if (DATA_VALID === 1'b1) begin
				chk(DATA, e0 + 16'(n));
				n++;
			end
		end
		chk(16'(n), {4'h0, rq.count});
		if (t >= 20000) begin
			fails++;
			$display("[FAIL] %0t: %s hung", $time, nm);
		end
		$display("%s done", nm);
	endtask : xfer
	task automatic t_page;
		xfer("page", req_type'{REQ_PAGE, 16'h0010, 16'h0003, 12'h4}, 16'h3010);
	endtask : t_page
	task automatic t_rand;
		xfer("rand", req_type'{REQ_RAND, 16'h07fe, 16'h0, 12'h3}, 16'h37fe);
	endtask : t_rand
	task automatic t_id;
		xfer("id", req_type'{REQ_ID, 16'h0, 16'h0, 12'h5}, 16'h00c0);
	endtask : t_id
	task automatic t_poll;
		xfer("poll", req_type'{REQ_POLL_PAGE, 16'h2, 16'h5, 12'h2}, 16'h5002);
	endtask : t_poll
	task automatic t_cache;
		xfer("cache", req_type'{REQ_CACHE, 16'h0, 16'h0, 12'h2}, 16'h5000);
		xfer("cache2", req_type'{REQ_CACHE, 16'h0, 16'h0, 12'h1}, 16'h6000);
		xfer("last", req_type'{REQ_LAST, 16'h0, 16'h0, 12'h2}, 16'h7000);
	endtask : t_cache
	task automatic results;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results
	initial begin
		repeat (8) @(posedge SYS_CLK);
		SRST <= 1'b0;
		t_page();
		t_rand();
		t_id();
		t_poll();
		t_cache();
		results();
	end
	initial begin
		#400000;
		fails++;
		$display("[FAIL] %0t: watchdog", $time);
		results();
	end
endmodule : nand_read_command_path_tb
`default_nettype wire
